// ---- verilog/hofc_params.svh ----
// constants for the hall output filter, clamp and diagnostics block
`ifndef HOFC_PARAMS_SVH
`define HOFC_PARAMS_SVH

// ============================================================
// timing: rates in Hz, cycle counts derived from the clock
// ============================================================
`define HOFC_CLK_HZ 10000000
`define HOFC_LP_RATE_HZ 16000
`define HOFC_DAC_RATE_HZ 256000
`define HOFC_LP_DIV (`HOFC_CLK_HZ / `HOFC_LP_RATE_HZ)
`define HOFC_DAC_DIV (`HOFC_CLK_HZ / `HOFC_DAC_RATE_HZ)
`define HOFC_DIV_W 10

// ============================================================
// data path widths and shaping
// ============================================================
`define HOFC_ADC_W 16
`define HOFC_CODE_W 12
`define HOFC_WIDE_W 20
`define HOFC_CODE_MAX 12'hfff
`define HOFC_SAT_HI 20'sh00fff
`define HOFC_CODE_MID 20'sh00800
`define HOFC_IN_SHIFT 3
`define HOFC_ACC_W 24
`define HOFC_LP_FRAC 8
`define HOFC_LP_BYPASS 3'h7
`define HOFC_LP_SHIFT_TOP 3'h7
`define HOFC_INT_STEPS 5'h10
`define HOFC_INT_SHIFT 4
`define HOFC_EE_W 16
`define HOFC_BAD_MAX 2'h2

// ============================================================
// register map (byte offsets, low address byte decoded)
// ============================================================
`define HOFC_OFF_LP 8'h00
`define HOFC_OFF_CL 8'h04
`define HOFC_OFF_CH 8'h08
`define HOFC_OFF_STAT 8'h0c
`define HOFC_OFF_IEN 8'h10
`define HOFC_OFF_ICLR 8'h14
`define HOFC_OFF_CODE 8'h18
`define HOFC_RST_LP 3'h0
`define HOFC_RST_CL 12'h000
`define HOFC_RST_CH 12'hfff

// ============================================================
// status bits
// ============================================================
`define HOFC_ST_W 4
`define HOFC_ST_EE_FIX 0
`define HOFC_ST_EE_FAIL 1
`define HOFC_ST_SUPPLY 2
`define HOFC_ST_CLAMP 3

`endif

// ---- verilog/hofc_pkg.sv ----
// types and shared arithmetic for the hall output filter block
`default_nettype none
package hofc_pkg;
`include "hofc_params.svh"

	// eeprom integrity state
	typedef enum logic {EES_SCAN, EES_FAIL} hofc_ee_st_t;

	typedef struct packed {
		logic signed [`HOFC_ACC_W-1:0] acc;
		logic signed [`HOFC_ADC_W-1:0] y;
		logic vld;
	} hofc_lp_st_t;

	typedef struct packed {
		logic [`HOFC_CODE_W-1:0] prev;
		logic [`HOFC_CODE_W-1:0] tgt;
		logic [4:0] k;
		logic [`HOFC_CODE_W-1:0] out;
		logic vld;
	} hofc_int_st_t;

	typedef struct packed {
		logic hrdy;
		logic [31:0] hrdata;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [2:0] lp_sel;
		logic [`HOFC_CODE_W-1:0] cl;
		logic [`HOFC_CODE_W-1:0] ch;
		logic [`HOFC_ST_W-1:0] status;
		logic [`HOFC_ST_W-1:0] irq_en;
		logic irq;
		logic [`HOFC_DIV_W-1:0] lp_cnt;
		logic [`HOFC_DIV_W-1:0] dac_cnt;
		logic lp_tick;
		logic dac_tick;
		logic [1:0] ee_bad;
		hofc_ee_st_t ee_st;
		logic [`HOFC_CODE_W-1:0] dac_code;
		logic dac_stb;
	} hofc_top_st_t;

	// limit a wide signed value to the unsigned output code range
	function automatic logic [`HOFC_CODE_W-1:0] hofc_sat12(
		input logic signed [`HOFC_WIDE_W-1:0] v);
		if (v < 0) begin
			return '0;
		end else if (v > `HOFC_SAT_HI) begin
			return `HOFC_CODE_MAX;
		end
		return v[`HOFC_CODE_W-1:0];
	endfunction : hofc_sat12

endpackage : hofc_pkg
`default_nettype wire

// ---- verilog/hofc_lowpass.sv ----
// selectable first order input low-pass, unity dc gain
`timescale 1ns/1ns
`default_nettype none
`include "hofc_params.svh"
module hofc_lowpass (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic signed [`HOFC_ADC_W-1:0] x_i,
	input wire logic valid_i,
	input wire logic [2:0] sel_i,
	output logic signed [`HOFC_ADC_W-1:0] y_o,
	output logic valid_o
);
	hofc_pkg::hofc_lp_st_t st_reg, st_next;

	// ============================================================
	// filter update, one step per input sample
	// ============================================================
	always_comb begin
		logic signed [`HOFC_ACC_W-1:0] xs;
		logic signed [`HOFC_ACC_W:0] diff;
		logic [2:0] sh;
		xs = {x_i, {`HOFC_LP_FRAC{1'b0}}};
		diff = (`HOFC_ACC_W+1)'(xs) - (`HOFC_ACC_W+1)'(st_reg.acc);
		sh = `HOFC_LP_SHIFT_TOP - sel_i;
		st_next = st_reg;
		st_next.vld = 1'b0;
		if (valid_i) begin
			if (sel_i == `HOFC_LP_BYPASS) begin
				st_next.acc = xs; // filter off
			end else begin
				// y += (x - y) / 2^sh keeps dc gain exactly one
				st_next.acc = st_reg.acc
					+ `HOFC_ACC_W'(diff >>> sh);
			end
			st_next.y = st_next.acc[`HOFC_ACC_W-1:`HOFC_LP_FRAC];
			st_next.vld = 1'b1; // one result per 16 kHz tick
		end
	end

	// state register, frozen while the clock enable is low
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			st_reg <= '0;
		end else if (clk_en_i) begin
			st_reg <= st_next;
		end
	end

	assign y_o = st_reg.y;
	assign valid_o = st_reg.vld;
endmodule : hofc_lowpass
`default_nettype wire

// ---- verilog/hofc_interp.sv ----
// always-on linear interpolator from 16 kHz codes to the dac rate
`timescale 1ns/1ns
`default_nettype none
`include "hofc_params.svh"
module hofc_interp (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic new_i,
	input wire logic [`HOFC_CODE_W-1:0] code_i,
	input wire logic step_i,
	output logic [`HOFC_CODE_W-1:0] code_o,
	output logic valid_o
);
	hofc_pkg::hofc_int_st_t st_reg, st_next;

	// ============================================================
	// ramp from the last output toward the newest code
	// ============================================================
	always_comb begin
		logic signed [`HOFC_WIDE_W-1:0] diff;
		logic signed [`HOFC_WIDE_W-1:0] prod;
		diff = '0;
		prod = '0;
		st_next = st_reg;
		st_next.vld = 1'b0;
		// new sample restarts the ramp from where the output stands
		if (new_i) begin
			st_next.prev = st_reg.out;
			st_next.tgt = code_i;
			st_next.k = '0;
		end
		diff = `HOFC_WIDE_W'(signed'({1'b0, st_next.tgt}))
			- `HOFC_WIDE_W'(signed'({1'b0, st_next.prev}));
		// no bypass exists: every dac sample passes here
		if (step_i) begin
			if (st_next.k < `HOFC_INT_STEPS) begin
				st_next.k = st_next.k + 5'h01;
			end
			prod = diff * `HOFC_WIDE_W'(signed'({1'b0, st_next.k}));
			st_next.out = hofc_pkg::hofc_sat12(
				`HOFC_WIDE_W'(signed'({1'b0, st_next.prev}))
				+ (prod >>> `HOFC_INT_SHIFT));
			st_next.vld = 1'b1;
		end
	end

	// state register, frozen while the clock enable is low
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			st_reg <= '0;
		end else if (clk_en_i) begin
			st_reg <= st_next;
		end
	end

	assign code_o = st_reg.out;
	assign valid_o = st_reg.vld;
endmodule : hofc_interp
`default_nettype wire

// ---- verilog/hofc_top.sv ----
// hall output back end: filters, clamp, diagnostics, ahb-lite regs
//
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "hofc_params.svh"
module hofc_top (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	// ahb-lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// converter samples and supply monitor
	input wire logic signed [`HOFC_ADC_W-1:0] adc_data_i,
	input wire logic supply_low_i,
	input wire logic supply_high_i,
	// eeprom line stream with per-line even parity
	input wire logic ee_valid_i,
	input wire logic [`HOFC_EE_W-1:0] ee_data_i,
	input wire logic ee_par_i,
	input wire logic ee_last_i,
	// filtered samples and dac feed
	output logic signed [`HOFC_ADC_W-1:0] lp_data_o,
	output logic lp_valid_o,
	output logic [`HOFC_CODE_W-1:0] dac_code_o,
	output logic dac_strobe_o,
	output logic irq_o
);
	hofc_pkg::hofc_top_st_t st_reg, st_next;

	logic signed [`HOFC_ADC_W-1:0] lp_y;
	logic lp_vld;
	logic [`HOFC_CODE_W-1:0] sat_code;
	logic [`HOFC_CODE_W-1:0] int_code;
	logic int_vld;

	// ============================================================
	// shared decode and arithmetic
	// ============================================================
	// low limit first, then high, so high wins when the two cross
	// equal limits pin the output to one fixed code
	function automatic logic [`HOFC_CODE_W-1:0] clamp_code(
		input logic [`HOFC_CODE_W-1:0] c,
		input logic [`HOFC_CODE_W-1:0] lo,
		input logic [`HOFC_CODE_W-1:0] hi);
		logic [`HOFC_CODE_W-1:0] r;
		r = c;
		if (r < lo) begin
			r = lo;
		end
		if (r > hi) begin
			r = hi;
		end
		return r;
	endfunction : clamp_code

	// odd parity over data and parity bit marks a line as bad
	// repair belongs to the line reader; here lines are only classified
	function automatic logic line_bad(
		input logic [`HOFC_EE_W-1:0] d,
		input logic p);
		return ^{d, p};
	endfunction : line_bad

	// register read mux; write-only and unmapped offsets read zero
	// a read sees the state before a write of the same cycle lands
	function automatic logic [31:0] reg_read(
		input logic [7:0] addr,
		input hofc_pkg::hofc_top_st_t s);
		logic [31:0] r;
		r = '0;
		case (addr)
			`HOFC_OFF_LP: begin
				r = 32'(s.lp_sel);
			end
			`HOFC_OFF_CL: begin
				r = 32'(s.cl);
			end
			`HOFC_OFF_CH: begin
				r = 32'(s.ch);
			end
			`HOFC_OFF_STAT: begin
				r = 32'(s.status);
			end
			`HOFC_OFF_IEN: begin
				r = 32'(s.irq_en);
			end
			`HOFC_OFF_CODE: begin
				r = 32'(s.dac_code);
			end
			default: begin
				r = '0;
			end
		endcase
		return r;
	endfunction : reg_read

	// ============================================================
	// filter stages
	// ============================================================
	hofc_lowpass u_lowpass (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.clk_en_i(clk_en_i),
		.x_i(adc_data_i),
		.valid_i(st_reg.lp_tick),
		.sel_i(st_reg.lp_sel),
		.y_o(lp_y),
		.valid_o(lp_vld)
	);

	// scale filtered value to an offset-binary code and limit it
	assign sat_code = hofc_pkg::hofc_sat12(
		`HOFC_WIDE_W'(lp_y >>> `HOFC_IN_SHIFT)
		+ `HOFC_CODE_MID);

	hofc_interp u_interp (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.clk_en_i(clk_en_i),
		.new_i(lp_vld),
		.code_i(sat_code),
		.step_i(st_reg.dac_tick),
		.code_o(int_code),
		.valid_o(int_vld)
	);

	// ============================================================
	// next state of the whole top level
	// ============================================================
	always_comb begin
		logic [`HOFC_ST_W-1:0] set_bits;
		logic [`HOFC_ST_W-1:0] clr_bits;
		logic [`HOFC_CODE_W-1:0] c;
		logic [1:0] bad;
		logic err;
		logic take;
		set_bits = '0;
		clr_bits = '0;
		c = int_code;
		bad = st_reg.ee_bad;
		err = 1'b0;
		take = 1'b0;
		st_next = st_reg;
		st_next.hrdy = 1'b1;
		st_next.lp_tick = 1'b0;
		st_next.dac_tick = 1'b0;
		st_next.dac_stb = 1'b0;

		// rate dividers; 256 kHz rounds down to a whole cycle count
		if (st_reg.lp_cnt == `HOFC_DIV_W'(`HOFC_LP_DIV - 1)) begin
			st_next.lp_cnt = '0;
			st_next.lp_tick = 1'b1;
		end else begin
			st_next.lp_cnt = st_reg.lp_cnt + `HOFC_DIV_W'(1);
		end
		if (st_reg.dac_cnt == `HOFC_DIV_W'(`HOFC_DAC_DIV - 1)) begin
			st_next.dac_cnt = '0;
			st_next.dac_tick = 1'b1;
		end else begin
			st_next.dac_cnt = st_reg.dac_cnt + `HOFC_DIV_W'(1);
		end

		// eeprom scan: count lines whose parity fails
		if (ee_valid_i) begin
			if (line_bad(ee_data_i, ee_par_i)) begin
				if (bad != `HOFC_BAD_MAX) begin
					bad = bad + 2'h1;
				end
			end
			st_next.ee_bad = bad;
			if (ee_last_i) begin
				st_next.ee_bad = '0;
				// a second bad line cannot be repaired
				if (bad == `HOFC_BAD_MAX) begin
					st_next.ee_st = hofc_pkg::EES_FAIL;
					set_bits[`HOFC_ST_EE_FAIL] = 1'b1;
				end else if (bad != 2'h0) begin
					// single line repaired, output untouched
					set_bits[`HOFC_ST_EE_FIX] = 1'b1;
				end
			end
		end

		// error sources, latched eeprom failure holds until reset
		case (st_reg.ee_st)
			hofc_pkg::EES_SCAN: begin
				err = 1'b0;
			end
			hofc_pkg::EES_FAIL: begin
				err = 1'b1;
			end
			default: begin
				err = 1'b1;
			end
		endcase
		if (supply_low_i || supply_high_i) begin
			err = 1'b1;
			set_bits[`HOFC_ST_SUPPLY] = 1'b1;
		end

		// per-sample clamp ahead of the error override
		if (int_vld) begin
			c = clamp_code(int_code, st_reg.cl, st_reg.ch);
			if (err) begin
				st_next.dac_code = `HOFC_CODE_MAX;
			end else begin
				st_next.dac_code = c;
				set_bits[`HOFC_ST_CLAMP] = (c != int_code);
			end
			st_next.dac_stb = 1'b1;
		end

		// ahb data phase of a write taken last cycle
		if (st_reg.wr_pend) begin
			st_next.wr_pend = 1'b0;
			case (st_reg.wr_addr)
				`HOFC_OFF_LP: begin
					st_next.lp_sel = hwdata_i[2:0];
				end
				`HOFC_OFF_CL: begin
					st_next.cl = hwdata_i[`HOFC_CODE_W-1:0];
				end
				`HOFC_OFF_CH: begin
					st_next.ch = hwdata_i[`HOFC_CODE_W-1:0];
				end
				`HOFC_OFF_IEN: begin
					st_next.irq_en = hwdata_i[`HOFC_ST_W-1:0];
				end
				`HOFC_OFF_ICLR: begin
					clr_bits = hwdata_i[`HOFC_ST_W-1:0];
				end
				default: begin
					st_next.wr_pend = 1'b0;
				end
			endcase
		end

		// ahb address phase; zero wait states, reads answered here
		take = hsel_i && htrans_i[1] && hready_i;
		st_next.hrdata = '0;
		if (take && hwrite_i) begin
			st_next.wr_pend = 1'b1;
			st_next.wr_addr = haddr_i[7:0];
		end
		if (take && !hwrite_i) begin
			st_next.hrdata = reg_read(haddr_i[7:0], st_reg);
		end

		// sticky status: a new event beats a clear in the same cycle
		st_next.status = (st_reg.status & ~clr_bits) | set_bits;
		st_next.irq = |(st_next.status & st_next.irq_en);
	end

	// ============================================================
	// state register
	// ============================================================
	// everything, bus included, freezes while the enable is low
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			st_reg <= '0;
			st_reg.lp_sel <= `HOFC_RST_LP;
			st_reg.cl <= `HOFC_RST_CL;
			st_reg.ch <= `HOFC_RST_CH;
			st_reg.ee_st <= hofc_pkg::EES_SCAN;
		end else if (clk_en_i) begin
			st_reg <= st_next;
		end
	end

	// outputs straight from state flops, except hresp, which is tied low
	assign hrdata_o = st_reg.hrdata;
	assign hreadyout_o = st_reg.hrdy;
	assign hresp_o = 1'b0; // always okay
	assign lp_data_o = lp_y;
	assign lp_valid_o = lp_vld;
	assign dac_code_o = st_reg.dac_code;
	assign dac_strobe_o = st_reg.dac_stb;
	assign irq_o = st_reg.irq;
endmodule : hofc_top
`default_nettype wire

// ---- testbench/hofc_top_assertions.sv ----
// port checker for the hall output back end
`timescale 1ns/1ns
`default_nettype none
module hofc_top_assertions (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic supply_low_i,
	input wire logic supply_high_i,
	input wire logic ee_valid_i,
	input wire logic [15:0] ee_data_i,
	input wire logic ee_par_i,
	input wire logic ee_last_i,
	input wire logic lp_valid_o,
	input wire logic [11:0] dac_code_o,
	input wire logic dac_strobe_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	// ============================================================
	// helper state
	logic [9:0] lp_gap_reg;
	logic [9:0] dac_gap_reg;
	logic lp_seen_reg;
	logic dac_seen_reg;
	logic [1:0] ee_bad_reg;
	logic ee_fail_reg;
	logic ee_bad;
	// odd parity over data and parity bit marks a bad line
	assign ee_bad = ^{ee_data_i, ee_par_i};
	// gaps between pulses; the first pulse after reset has no reference
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			lp_gap_reg <= 10'h000;
			dac_gap_reg <= 10'h000;
			lp_seen_reg <= 1'b0;
			dac_seen_reg <= 1'b0;
			ee_bad_reg <= 2'h0;
			ee_fail_reg <= 1'b0;
		end else begin
			lp_gap_reg <= lp_valid_o ? 10'h000 : lp_gap_reg + 10'h001;
			dac_gap_reg <= dac_strobe_o ? 10'h000 : dac_gap_reg + 10'h001;
			lp_seen_reg <= lp_seen_reg | lp_valid_o;
			dac_seen_reg <= dac_seen_reg | dac_strobe_o;
			if (ee_valid_i && ee_last_i) begin
				ee_fail_reg <= ee_fail_reg |
					(ee_bad_reg + {1'b0, ee_bad} >= 2'h2);
				ee_bad_reg <= 2'h0;
			end else if (ee_valid_i && ee_bad && ee_bad_reg != 2'h2) begin
				ee_bad_reg <= ee_bad_reg + 2'h1;
			end
		end
	end
	// ============================================================
	// properties
	sequence supply_held;
		(supply_low_i || supply_high_i) [*3];
	endsequence
	a_lp_period: assert property (
		lp_valid_o && lp_seen_reg |-> lp_gap_reg == 10'h270)
		else $error("filter samples not 625 cycles apart");
	a_lp_pulse: assert property (
		lp_valid_o |=> !lp_valid_o)
		else $error("filter valid longer than one cycle");
	a_dac_period: assert property (
		dac_strobe_o && dac_seen_reg |-> dac_gap_reg == 10'h026)
		else $error("dac strobes not 39 cycles apart");
	a_dac_pulse: assert property (
		dac_strobe_o |=> !dac_strobe_o)
		else $error("dac strobe longer than one cycle");
	a_code_hold: assert property (
		!dac_strobe_o |-> $stable(dac_code_o))
		else $error("dac code moved without a strobe");
	a_supply_force: assert property (
		supply_held ##1 dac_strobe_o |-> dac_code_o == 12'hfff)
		else $error("supply fault did not force top code");
	a_eeprom_force: assert property (
		$past(ee_fail_reg, 2) && dac_strobe_o |-> dac_code_o == 12'hfff)
		else $error("eeprom failure did not force top code");
	a_bus_ready: assert property (
		!reset_i |=> hreadyout_o)
		else $error("bus ready dropped");
	a_bus_okay: assert property (
		hresp_o == 1'b0)
		else $error("bus response not okay");
endmodule : hofc_top_assertions
bind hofc_top hofc_top_assertions u_chk (.sys_clk_i, .reset_i,
	.hreadyout_o, .hresp_o, .supply_low_i, .supply_high_i, .ee_valid_i,
	.ee_data_i, .ee_par_i, .ee_last_i, .lp_valid_o, .dac_code_o,
	.dac_strobe_o);
`default_nettype wire

// ---- testbench/hofc_mcu_model.sv ----
// host side sampler of the dac output stream
`timescale 1ns/1ns
`default_nettype none
module hofc_mcu_model (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [11:0] dac_code_i,
	input wire logic dac_strobe_i,
	output logic [11:0] seen_code_o
);
	// take the code only on a strobe, as the output converter would
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			seen_code_o <= 12'h000;
		end else if (dac_strobe_i) begin
			seen_code_o <= dac_code_i;
		end
	end
endmodule : hofc_mcu_model
`default_nettype wire

// ---- testbench/test_hall_output_filter_clamp_diag.sv ----
// self-checking bench for the hall output back end
`timescale 1ns/1ns
`default_nettype none
module test_hall_output_filter_clamp_diag;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0, hwrite = 1'b0, hready, hresp;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic signed [15:0] adc = '0, lp_d;
	logic sup_lo = 1'b0, sup_hi = 1'b0, ee_v = 1'b0, ee_p = 1'b0;
	logic ee_l = 1'b0, lp_v, dstb, irq;
	logic [15:0] ee_d = '0;
	logic [11:0] dcode, mcode, lo, hi, e;
	int error_cnt = 0, checks = 0;
	// ============================================================
	// clock, design and host sampler
	always #50 sys_clk = ~sys_clk;
	hofc_top uut (.sys_clk_i(sys_clk), .reset_i(rst), .clk_en_i(1'b1),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.adc_data_i(adc), .supply_low_i(sup_lo), .supply_high_i(sup_hi),
		.ee_valid_i(ee_v), .ee_data_i(ee_d), .ee_par_i(ee_p),
		.ee_last_i(ee_l), .lp_data_o(lp_d), .lp_valid_o(lp_v),
		.dac_code_o(dcode), .dac_strobe_o(dstb), .irq_o(irq));
	hofc_mcu_model mcu (.sys_clk_i(sys_clk), .reset_i(rst),
		.dac_code_i(dcode), .dac_strobe_i(dstb), .seen_code_o(mcode));
	// ============================================================
	// tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc
	// single word transfer; waits on ready, never assumes wait states
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge sys_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge sys_clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
		bus(1'b0, a, 32'h0);
		chk(rd, x);
	endtask : rdchk
	// four eeprom lines, the first nbad of them with broken parity
	task automatic scan(input int nbad);
		logic [15:0] d;
		for (int i = 0; i < 4; i++) begin
			d = 16'($urandom);
			ee_d <= d;
			ee_p <= ^d ^ (i < nbad);
			ee_v <= 1'b1;
			ee_l <= (i == 3);
			@(posedge sys_clk);
		end
		ee_v <= 1'b0;
		ee_l <= 1'b0;
		cyc(2);
	endtask : scan
	// offset to code, saturate, then low clamp and high clamp last
	function automatic logic [11:0] exp_code(input logic signed [15:0] x,
		input logic [11:0] l, input logic [11:0] h);
		logic signed [19:0] v;
		logic [11:0] c;
		v = (20'(x) >>> 3) + 20'sh00800;
		c = (v < 0) ? 12'h000 : (v > 20'sh00fff) ? 12'hfff : v[11:0];
		if (c < l)
			c = l;
		if (c > h)
			c = h;
		return c;
	endfunction : exp_code
	task automatic test_done;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done
	// watchdog: about twice the expected run
	initial begin
		#6000000;
		error_cnt++;
		test_done();
	end
	// ============================================================
	// main sequence
	initial begin
		void'($urandom(32'h68033657));
		cyc(4);
		rst <= 1'b0;
		cyc(1);
		rdchk(8'h00, 32'h0);
		rdchk(8'h04, 32'h0);
		rdchk(8'h08, 32'hfff);
		rdchk(8'h1c, 32'h0);
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, 8'h00, {29'($urandom), 3'(i)});
			rdchk(8'h00, 32'(i));
		end
		lo = 12'($urandom);
		bus(1'b1, 8'h04, {20'($urandom), lo});
		rdchk(8'h04, {20'h0, lo});
		bus(1'b1, 8'h08, {20'($urandom), lo});
		rdchk(8'h08, {20'h0, lo});
		// bypass: bottom saturation, visible ramp, exact pass-through
		bus(1'b1, 8'h00, 32'h7);
		bus(1'b1, 8'h04, 32'h0);
		bus(1'b1, 8'h08, 32'hfff);
		adc <= 16'sh8000;
		cyc(2000);
		chk(mcode, 32'h0);
		adc <= 16'($urandom & 32'h3fff);
		// skip a filter pulse that may still carry the old sample
		cyc(2);
		e = exp_code(adc, 12'h000, 12'hfff);
		for (int n = 0; n < 700 && lp_v !== 1'b1; n++) @(posedge sys_clk);
		cyc(312);
		chk(32'(mcode > 12'h000 && mcode < e), 32'h1);
		cyc(2000);
		chk(lp_d, adc);
		chk(mcode, e);
		rdchk(8'h18, {20'h0, e});
		// filtered setting settles to the input within one step
		bus(1'b1, 8'h00, 32'h6);
		adc <= 16'($urandom & 32'h3fff);
		cyc(20000);
		chk(32'(lp_d >= adc - 16'sd1 && lp_d <= adc + 16'sd1), 32'h1);
		// clamp window inside error levels; last case crosses the clamps
		bus(1'b1, 8'h00, 32'h7);
		for (int i = 0; i < 3; i++) begin
			lo = 12'h100 + 12'($urandom & 32'h3ff);
			hi = lo + 12'h400;
			if (i == 2)
				{lo, hi} = {hi, lo};
			adc <= (i == 1) ? 16'sh7fff : 16'sh8000;
			bus(1'b1, 8'h04, {20'h0, lo});
			bus(1'b1, 8'h08, {20'h0, hi});
			cyc(2000);
			chk(mcode, exp_code(adc, lo, hi));
		end
		rdchk(8'h0c, 32'h8);
		bus(1'b1, 8'h04, 32'h0);
		bus(1'b1, 8'h08, 32'hfff);
		bus(1'b1, 8'h14, 32'hf);
		rdchk(8'h0c, 32'h0);
		// supply faults raise the enabled interrupt, then masked
		bus(1'b1, 8'h10, 32'h4);
		rdchk(8'h10, 32'h4);
		for (int k = 0; k < 2; k++) begin
			sup_lo <= (k == 0);
			sup_hi <= (k == 1);
			cyc(100);
			chk(mcode, 32'hfff);
			chk(irq, 1'b1);
			sup_lo <= 1'b0;
			sup_hi <= 1'b0;
			bus(1'b1, 8'h14, 32'hf);
			cyc(3);
			chk(irq, 1'b0);
		end
		bus(1'b1, 8'h10, 32'h0);
		sup_lo <= 1'b1;
		cyc(10);
		chk(irq, 1'b0);
		rdchk(8'h0c, 32'h4);
		sup_lo <= 1'b0;
		bus(1'b1, 8'h14, 32'hf);
		// one bad line is corrected, two are fatal until reset
		cyc(200);
		scan(1);
		rdchk(8'h0c, 32'h1);
		cyc(100);
		chk(mcode, 32'h0);
		bus(1'b1, 8'h14, 32'hf);
		scan(2);
		bus(1'b0, 8'h0c, 32'h0);
		chk(rd[1], 1'b1);
		cyc(100);
		chk(mcode, 32'hfff);
		rst <= 1'b1;
		cyc(4);
		rst <= 1'b0;
		cyc(1);
		rdchk(8'h0c, 32'h0);
		rdchk(8'h08, 32'hfff);
		test_done();
	end
endmodule : test_hall_output_filter_clamp_diag
`default_nettype wire
